// ===== bench/dcr_host.sv
/*
 * Behavioural host for the three-wire control port.
 * Assumes core_clk at 100 MHz; the link clock has an 80 ns period.
 */
`timescale 1ns/10ps
module dcr_host
(
    // timing reference
    input  wire logic core_clk,
    // control port
    output logic      ctrl_mode_line,
    output logic      ctrl_clock_line,
    output logic      host_d,
    output logic      host_oe,
    input  wire logic data_wire
);
    initial
    begin
        ctrl_mode_line  = 1'b0;
        ctrl_clock_line = 1'b1;
        host_d          = 1'b0;
        host_oe         = 1'b1;
    end

    // first-in-time bit in v[7]; clock stands high between bytes
    task automatic send(input logic mode, input logic [7:0] v);
        @(posedge core_clk);
        #1 ctrl_mode_line = mode;
        #80;
        for (int i = 7; i >= 0; i--)
        begin
            host_d          = v[i];
            ctrl_clock_line = 1'b0;
            #40 ctrl_clock_line = 1'b1;
            #40;
        end
    endtask : send

    // 8'h58 is the write address byte for device address 6'h06
    task automatic write(input logic [6:0] r, input logic [15:0] d);
        send(1'b0, 8'h58);
        send(1'b1, {1'b0, r});
        send(1'b1, d[15:8]);
        send(1'b1, d[7:0]);
        #80;
    endtask : write

    task automatic read(input logic [6:0] r, output logic [23:0] word);
        send(1'b0, 8'h58);
        send(1'b1, {1'b1, r});
        send(1'b0, 8'hD8);
        @(posedge core_clk);
        #1 ctrl_mode_line = 1'b1;
        host_oe = 1'b0;
        #80;
        for (int i = 0; i < 24; i++)
        begin
            ctrl_clock_line = 1'b0;
            #40 word = {word[22:0], data_wire};
            ctrl_clock_line = 1'b1;
            #40;
        end
        host_oe = 1'b1;
    endtask : read
endmodule : dcr_host

// ===== bench/dcr_top_tb_top.sv
/*
 * Self-checking bench of the DAC control register bank.
 * Assumes the design and its package are compiled first.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module dcr_top_tb_top;
    import dcr_pkg::*;
    logic       core_clk, rst, mode, sclk, host_d, host_oe, data_wire, dout, doe;
    logic       interp_mute, pll_locked, dec_locked, non_pcm, pre_emph;
    logic [1:0] rate_code, grade, serial_format, filter_mode, treble_level, deemphasis_select;
    logic       dac_power_on, slicer_input_select, regen_clock_source, clock_master;
    logic       dac_source_select, soft_mute_enable, volume_full_mute;
    logic       lock_loss_mute, hard_mute, pll_reset_hold;
    logic [3:0] bass_level;
    logic [5:0] volume_code, volume_atten_db, exp_db;
    logic [23:0] word;
    int         checks, fail_count;
    int         codes[8] = '{0, 1, 2, 30, 60, 61, 62, 63};

    // undriven line shows the inverse of the host's last bit
    assign data_wire = doe ? dout : (host_oe ? host_d : ~host_d);

    dcr_host host (.core_clk, .ctrl_mode_line(mode), .ctrl_clock_line(sclk), .host_d,
        .host_oe, .data_wire);

    dcr_top DUT (.core_clk, .rst, .ctrl_mode_line(mode), .ctrl_clock_line(sclk),
        .ctrl_data_line_in(data_wire), .ctrl_data_line_out(dout), .ctrl_data_line_oe(doe),
        .interpolator_muting(interp_mute), .pll_locked, .input_decoder_locked(dec_locked),
        .sample_rate_code(rate_code), .non_pcm_detected(non_pcm),
        .pre_emphasis_detected(pre_emph), .timing_grade(grade), .dac_power_on,
        .slicer_input_select, .regen_clock_source, .clock_master, .dac_source_select,
        .serial_format, .filter_mode, .bass_level, .treble_level, .deemphasis_select,
        .soft_mute_enable, .volume_code, .volume_atten_db, .volume_full_mute,
        .lock_loss_mute, .hard_mute, .pll_reset_hold);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results;
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic check_read(input logic [6:0] r, input logic [15:0] d);
        host.read(r, word);
        `CHK(word, {1'b0, r, d})
    endtask : check_read

    task automatic check_defaults;
        `CHK({dac_power_on, slicer_input_select, regen_clock_source, clock_master, dac_source_select, serial_format}, 7'b1001100)
        `CHK({filter_mode, bass_level, treble_level, deemphasis_select, soft_mute_enable}, 11'h001)
        `CHK({volume_code, lock_loss_mute, pll_reset_hold}, 8'h02)
    endtask : check_defaults

    task automatic set_lock(input logic v);
        @(posedge core_clk);
        #1 pll_locked = v;
        repeat (3) @(posedge core_clk);
    endtask : set_lock

    initial
    begin
        #400000;
        fail_count++;
        results();
    end

    initial
    begin
        {rst, interp_mute, pll_locked, dec_locked, non_pcm, pre_emph} = 6'b110111;
        {rate_code, grade} = 4'b1001;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        check_defaults();
        host.write(REG_MULTIPLEX, 16'h0003);
        `CHK({lock_loss_mute, pll_reset_hold, hard_mute}, 3'b111)
        check_read(REG_MULTIPLEX, 16'h0003);
        set_lock(1'b1);
        `CHK(hard_mute, 1'b0)
        host.write(REG_MULTIPLEX, 16'h0000);
        set_lock(1'b0);
        `CHK({lock_loss_mute, pll_reset_hold, hard_mute}, 3'b000)
        host.write(REG_SYSTEM, 16'hFFFF);
        `CHK({dac_power_on, slicer_input_select, regen_clock_source, clock_master, dac_source_select, serial_format}, 7'b1110111)
        check_read(REG_SYSTEM, 16'h2658);
        for (int f = 0; f < 4; f++)
        begin
            host.write(REG_SYSTEM, {11'h000, f[1:0], 3'b000});
            `CHK({dac_power_on, slicer_input_select, clock_master, dac_source_select, serial_format}, {4'b0010, f[1:0]})
            host.write(REG_SOUND, {2'b00, f[1:0], 4'hA, 3'b000, 2'b10, 2'b01, 1'b0});
            `CHK({filter_mode, bass_level, treble_level, deemphasis_select, soft_mute_enable}, {f[1:0], 4'hA, 2'b10, 2'b01, 1'b0})
        end
        foreach (codes[i])
        begin
            host.write(REG_VOLUME, {10'h000, codes[i][5:0]});
            exp_db = (codes[i] < 2) ? 6'h00 : ((codes[i] > 61) ? 6'h3C : codes[i][5:0] - 6'h01);
            `CHK({volume_code, volume_full_mute}, {codes[i][5:0], codes[i] > 61})
            if (codes[i] < 62)
                `CHK(volume_atten_db, exp_db)
        end
        check_read(REG_LOCK, 16'h01A9);
        check_read(REG_INTERP, 16'h0001);
        host.write(REG_LOCK, 16'h0000);
        check_read(REG_LOCK, 16'h01A9);
        host.read(7'h05, word);
        `CHK(word[23:16], 8'h85)
        host.write(REG_RESTORE, 16'h0000);
        check_defaults();
        check_read(REG_MULTIPLEX, 16'h0002);
        check_read(REG_LOCK, 16'h01A9);
        host.send(1'b0, 8'h5C);
        host.send(1'b1, {1'b0, REG_VOLUME});
        host.send(1'b1, 8'h00);
        host.send(1'b1, 8'h3F);
        #80;
        `CHK(volume_code, 6'h00)
        results();
    end
endmodule : dcr_top_tb_top

// ===== rtl/dcr_pkg.sv
/*
 * Constants of the DAC control register bank: register offsets, field
 * positions, write masks, default values and serial framing codes.
 * Assumes nothing of its surroundings.
 */
package dcr_pkg;

    // register offsets (7-bit destination address)
    localparam logic [6:0] REG_SYSTEM    = 7'h00;
    localparam logic [6:0] REG_SOUND     = 7'h10;
    localparam logic [6:0] REG_VOLUME    = 7'h11;
    localparam logic [6:0] REG_INTERP    = 7'h18;
    localparam logic [6:0] REG_LOCK      = 7'h38;
    localparam logic [6:0] REG_MULTIPLEX = 7'h40;
    localparam logic [6:0] REG_RESTORE   = 7'h7F;

    // writable bits and defaults
    localparam logic [15:0] SYSTEM_MASK    = 16'h2658;
    localparam logic [15:0] SYSTEM_DEF     = 16'h2040;
    localparam logic [15:0] SOUND_MASK     = 16'h3F1F;
    localparam logic [15:0] SOUND_DEF      = 16'h0001;
    localparam logic [15:0] VOLUME_MASK    = 16'h003F;
    localparam logic [15:0] VOLUME_DEF     = 16'h0000;
    localparam logic [15:0] MULTIPLEX_MASK = 16'h0003;
    localparam logic [15:0] MULTIPLEX_DEF  = 16'h0002;

    // field positions
    localparam int BIT_POWER_ON   = 13;
    localparam int BIT_SLICER_SEL = 10;
    localparam int BIT_REGEN_SRC  = 9;
    localparam int BIT_DAC_SRC    = 6;
    localparam int FMT_HI         = 4;
    localparam int FMT_LO         = 3;
    localparam int FILT_HI        = 13;
    localparam int FILT_LO        = 12;
    localparam int BASS_HI        = 11;
    localparam int BASS_LO        = 8;
    localparam int TREB_HI        = 4;
    localparam int TREB_LO        = 3;
    localparam int DEEMPH_HI      = 2;
    localparam int DEEMPH_LO      = 1;
    localparam int BIT_SOFT_MUTE  = 0;
    localparam int VOL_HI         = 5;
    localparam int BIT_LOCK_MUTE  = 1;
    localparam int BIT_PLL_RESET  = 0;

    // volume decoding
    localparam logic [5:0] VOL_ZERO_CODES = 6'h02;
    localparam logic [5:0] VOL_MAX_ATTEN  = 6'h3C;
    localparam logic [5:0] VOL_MUTE_CODE  = 6'h3E;
    localparam logic [5:0] VOL_STEP       = 6'h01;

    // serial framing
    localparam logic [5:0] DEV_ADDR_DEF = 6'h06;
    localparam logic [1:0] DOM_WRITE    = 2'h2;
    localparam logic [1:0] DOM_READ     = 2'h3;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam logic [4:0] READ_BITS    = 5'h17;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REG_ADDR,
        ST_DATA_HI,
        ST_DATA_LO,
        ST_READ_OUT
    } dcr_state_t;

endpackage : dcr_pkg

// ===== rtl/dcr_sync.sv
/*
 * Two-stage synchroniser for one level from outside the core clock domain.
 * Assumes core_clk runs continuously and rst is asynchronous, active high.
 */
`timescale 1ns/10ps
module dcr_sync
    import dcr_pkg::*;
#(
    // level held during reset; match the line's idle level
    parameter logic RESET_VAL = 1'b0
)
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // level
    input  wire logic d,
    output logic      q
);

    logic meta_reg;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= RESET_VAL;
            q        <= RESET_VAL;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule : dcr_sync

// ===== rtl/dcr_top.sv
/*
 * Control register bank of an audio DAC, reached over a three-wire serial
 * control port (mode, clock, data). Holds the writable settings, drives
 * them out as control levels and returns decoder status on reads.
 * Assumes the three control lines are asynchronous to core_clk, the status
 * inputs come from logic on core_clk, and the control clock is far slower
 * than core_clk. Bytes arrive bit 0 first; data bytes carry D15 first.
 */
//
// Behaviour
// - any write to 0x7F restores every writable field to default
// - restore touches control registers only; status and link state keep going
// - register 0x00 bit 13 powers the DAC on, default on
// - register 0x00 bit 10 picks slicer input, default input 0
// - register 0x00 bit 9 picks clock regeneration reference, default input
// - with input as clock source the device is clock master on ports
// - register 0x00 bit 6 picks DAC data source, default IEC input
// - register 0x00 bits 4:3 set serial format, default I2S
// - register 0x10 holds filter mode, bass, treble, de-emphasis, soft mute
// - soft mute bit mutes output when set, defaults to muting
// - lock-loss mute bit hard-mutes output on loss of lock, default set
// - PLL reset bit holds PLL in reset while set, default clear
// - six-bit volume attenuates both channels 0..-60 dB plus full mute
`timescale 1ns/10ps
module dcr_top
    import dcr_pkg::*;
#(
    parameter logic [5:0] DEV_ADDR = DEV_ADDR_DEF
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // serial control port
    input  wire logic       ctrl_mode_line,
    input  wire logic       ctrl_clock_line,
    input  wire logic       ctrl_data_line_in,
    output logic            ctrl_data_line_out,
    output logic            ctrl_data_line_oe,
    // status from the decoder and interpolator
    input  wire logic       interpolator_muting,
    input  wire logic       pll_locked,
    input  wire logic       input_decoder_locked,
    input  wire logic [1:0] sample_rate_code,
    input  wire logic       non_pcm_detected,
    input  wire logic       pre_emphasis_detected,
    input  wire logic [1:0] timing_grade,
    // system settings
    output logic            dac_power_on,
    output logic            slicer_input_select,
    output logic            regen_clock_source,
    output logic            clock_master,
    output logic            dac_source_select,
    output logic [1:0]      serial_format,
    // sound features
    output logic [1:0]      filter_mode,
    output logic [3:0]      bass_level,
    output logic [1:0]      treble_level,
    output logic [1:0]      deemphasis_select,
    output logic            soft_mute_enable,
    output logic [5:0]      volume_code,
    output logic [5:0]      volume_atten_db,
    output logic            volume_full_mute,
    // multiplex settings
    output logic            lock_loss_mute,
    output logic            hard_mute,
    output logic            pll_reset_hold
);

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = v[7 - i];
        end
    endfunction : rev8

    function automatic logic [15:0] upd(input logic [15:0] cur,
                                        input logic        hit,
                                        input logic        restore,
                                        input logic [15:0] data,
                                        input logic [15:0] mask,
                                        input logic [15:0] def);
        upd = restore ? def : (hit ? (data & mask) : cur);
    endfunction : upd

    logic       mode_s;
    logic       sclk_s;
    logic       sdata_s;

    dcr_sync u_sync_mode  (.core_clk(core_clk), .rst(rst), .d(ctrl_mode_line),    .q(mode_s));
    // control clock idles high; a low reset value would fake a rise after reset
    dcr_sync #(.RESET_VAL(1'b1)) u_sync_clock (.core_clk(core_clk), .rst(rst),
        .d(ctrl_clock_line), .q(sclk_s));
    dcr_sync u_sync_data  (.core_clk(core_clk), .rst(rst), .d(ctrl_data_line_in), .q(sdata_s));

    logic        sclk_d_reg;
    logic        mode_d_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  data_hi_reg;
    logic [6:0]  wr_addr_reg;
    logic [6:0]  rd_addr_reg;
    logic [23:0] rd_shift_reg;
    logic [4:0]  rd_cnt_reg;
    dcr_state_t  state_reg;
    dcr_state_t  state_next;
    logic [15:0] sys_reg;
    logic [15:0] snd_reg;
    logic [15:0] vol_reg;
    logic [15:0] mux_reg;

    // edge and byte detection on the synchronised lines
    wire        sclk_rise = sclk_s & ~sclk_d_reg;
    wire        mode_chg  = mode_s ^ mode_d_reg;
    wire        reading   = (state_reg == ST_READ_OUT);
    wire        byte_done = sclk_rise & ~mode_chg & ~reading & (bit_cnt_reg == LAST_BIT);
    wire [7:0]  byte_in   = {sdata_s, shift_reg[7:1]};
    wire [7:0]  byte_msb  = rev8(byte_in);
    wire        addr_byte = byte_done & ~mode_s;
    wire        data_byte = byte_done & mode_s;
    wire        dev_hit   = (byte_in[7:2] == DEV_ADDR);
    wire        dom_wr    = dev_hit & (byte_in[1:0] == DOM_WRITE);
    wire        dom_rd    = dev_hit & (byte_in[1:0] == DOM_READ);
    wire        out_shift = reading & mode_s & sclk_rise;
    wire        out_last  = out_shift & (rd_cnt_reg == READ_BITS);

    // write commit only after the second data byte
    wire        wr_commit = data_byte & (state_reg == ST_DATA_LO);
    wire [15:0] wr_data   = {data_hi_reg, byte_msb};
    wire        restore   = wr_commit & (wr_addr_reg == REG_RESTORE);
    wire        hit_sys   = wr_commit & (wr_addr_reg == REG_SYSTEM);
    wire        hit_snd   = wr_commit & (wr_addr_reg == REG_SOUND);
    wire        hit_vol   = wr_commit & (wr_addr_reg == REG_VOLUME);
    wire        hit_mux   = wr_commit & (wr_addr_reg == REG_MULTIPLEX);

    wire [15:0] sys_next  = upd(sys_reg, hit_sys, restore, wr_data, SYSTEM_MASK, SYSTEM_DEF);
    wire [15:0] snd_next  = upd(snd_reg, hit_snd, restore, wr_data, SOUND_MASK, SOUND_DEF);
    wire [15:0] vol_next  = upd(vol_reg, hit_vol, restore, wr_data, VOLUME_MASK, VOLUME_DEF);
    wire [15:0] mux_next  = upd(mux_reg, hit_mux, restore, wr_data, MULTIPLEX_MASK,
                                MULTIPLEX_DEF);

    // readback selection; status words built from live inputs
    wire [15:0] interp_word = {15'h0000, interpolator_muting};
    wire [15:0] lock_word   = {5'h00, pll_locked, 1'b0, input_decoder_locked,
                               sample_rate_code, non_pcm_detected, 1'b0,
                               pre_emphasis_detected, 1'b0, timing_grade};
    wire        rd_valid  = (rd_addr_reg == REG_SYSTEM) | (rd_addr_reg == REG_SOUND) |
                            (rd_addr_reg == REG_VOLUME) | (rd_addr_reg == REG_INTERP) |
                            (rd_addr_reg == REG_LOCK) | (rd_addr_reg == REG_MULTIPLEX);
    wire [15:0] rd_word   = (rd_addr_reg == REG_SYSTEM)    ? sys_reg     :
                            (rd_addr_reg == REG_SOUND)     ? snd_reg     :
                            (rd_addr_reg == REG_VOLUME)    ? vol_reg     :
                            (rd_addr_reg == REG_INTERP)    ? interp_word :
                            (rd_addr_reg == REG_LOCK)      ? lock_word   :
                            (rd_addr_reg == REG_MULTIPLEX) ? mux_reg     : 16'h0000;
    wire        rd_load   = addr_byte & dom_rd;

    // volume: codes 0,1 are 0 dB, then 1 dB per step, saturating; top codes mute
    wire [5:0]  vol_c     = vol_next[VOL_HI:0];
    wire [5:0]  vol_sub   = vol_c - VOL_STEP;
    wire [5:0]  atten_nx  = (vol_c < VOL_ZERO_CODES) ? 6'h00 :
                            (vol_sub > VOL_MAX_ATTEN) ? VOL_MAX_ATTEN : vol_sub;

    always_comb
    begin
        state_next = state_reg;
        if (addr_byte)
        begin
            state_next = dom_wr ? ST_REG_ADDR : (dom_rd ? ST_READ_OUT : ST_IDLE);
        end
        else if (data_byte)
        begin
            unique case (state_reg)
                ST_REG_ADDR: state_next = byte_msb[7] ? ST_IDLE : ST_DATA_HI;
                ST_DATA_HI:  state_next = ST_DATA_LO;
                ST_DATA_LO:  state_next = ST_IDLE;
                ST_IDLE:     state_next = ST_IDLE;
                ST_READ_OUT: state_next = ST_READ_OUT;
            endcase
        end
        else if (out_last | (reading & mode_chg & ~mode_s))
        begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_d_reg  <= 1'b1;
            mode_d_reg  <= 1'b0;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 3'h0;
            state_reg   <= ST_IDLE;
        end
        else
        begin
            sclk_d_reg  <= sclk_s;
            mode_d_reg  <= mode_s;
            shift_reg   <= sclk_rise ? byte_in : shift_reg;
            bit_cnt_reg <= mode_chg ? 3'h0 : (sclk_rise ? bit_cnt_reg + 3'h1 : bit_cnt_reg);
            state_reg   <= state_next;
        end
    end

    // latch destination addresses and the first data byte
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_addr_reg <= 7'h00;
            rd_addr_reg <= 7'h00;
            data_hi_reg <= 8'h00;
        end
        else
        begin
            if (data_byte && state_reg == ST_REG_ADDR && !byte_msb[7])
            begin
                wr_addr_reg <= byte_msb[6:0];
            end
            if (data_byte && state_reg == ST_REG_ADDR && byte_msb[7])
            begin
                rd_addr_reg <= byte_msb[6:0];
            end
            if (data_byte && state_reg == ST_DATA_HI)
            begin
                data_hi_reg <= byte_msb;
            end
        end
    end

    // read answer: flag and address byte, then D15 down to D0
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_shift_reg       <= 24'h000000;
            rd_cnt_reg         <= 5'h00;
            ctrl_data_line_out <= 1'b0;
            ctrl_data_line_oe  <= 1'b0;
        end
        else
        begin
            if (rd_load)
            begin
                rd_shift_reg <= {~rd_valid, rd_addr_reg, rd_word};
                rd_cnt_reg   <= 5'h00;
            end
            else if (out_shift)
            begin
                rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
                rd_cnt_reg   <= rd_cnt_reg + 5'h01;
            end
            ctrl_data_line_out <= rd_load ? ~rd_valid :
                                  (out_shift ? rd_shift_reg[22] : rd_shift_reg[23]);
            ctrl_data_line_oe  <= (state_next == ST_READ_OUT) & mode_s;
        end
    end

    // control registers; status and serial state are untouched by restore
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sys_reg          <= SYSTEM_DEF;
            snd_reg          <= SOUND_DEF;
            vol_reg          <= VOLUME_DEF;
            mux_reg          <= MULTIPLEX_DEF;
            clock_master     <= ~SYSTEM_DEF[BIT_REGEN_SRC];
            volume_atten_db  <= 6'h00;
            volume_full_mute <= 1'b0;
            hard_mute        <= 1'b0;
        end
        else
        begin
            sys_reg          <= sys_next;
            snd_reg          <= snd_next;
            vol_reg          <= vol_next;
            mux_reg          <= mux_next;
            clock_master     <= ~sys_next[BIT_REGEN_SRC];
            volume_atten_db  <= atten_nx;
            volume_full_mute <= (vol_c >= VOL_MUTE_CODE);
            hard_mute        <= mux_reg[BIT_LOCK_MUTE] & ~pll_locked;
        end
    end

    assign dac_power_on        = sys_reg[BIT_POWER_ON];
    assign slicer_input_select = sys_reg[BIT_SLICER_SEL];
    assign regen_clock_source  = sys_reg[BIT_REGEN_SRC];
    assign dac_source_select   = sys_reg[BIT_DAC_SRC];
    assign serial_format       = sys_reg[FMT_HI:FMT_LO];
    assign filter_mode         = snd_reg[FILT_HI:FILT_LO];
    assign bass_level          = snd_reg[BASS_HI:BASS_LO];
    assign treble_level        = snd_reg[TREB_HI:TREB_LO];
    assign deemphasis_select   = snd_reg[DEEMPH_HI:DEEMPH_LO];
    assign soft_mute_enable    = snd_reg[BIT_SOFT_MUTE];
    assign volume_code         = vol_reg[VOL_HI:0];
    assign lock_loss_mute      = mux_reg[BIT_LOCK_MUTE];
    assign pll_reset_hold      = mux_reg[BIT_PLL_RESET];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_RESTORE: assert property (restore |=> sys_reg == SYSTEM_DEF && snd_reg == SOUND_DEF
        && vol_reg == VOLUME_DEF && mux_reg == MULTIPLEX_DEF)
        else $error("restore did not return defaults");
    AST_RESTORE_KEEPS: assert property (restore |=> $stable(rd_addr_reg))
        else $error("restore disturbed serial read state");
    AST_POWER: assert property (hit_sys |=> dac_power_on == $past(wr_data[BIT_POWER_ON]))
        else $error("power bit not taken from write");
    AST_SLICER: assert property (hit_sys |=> slicer_input_select
        == $past(wr_data[BIT_SLICER_SEL]))
        else $error("slicer select not taken from write");
    AST_REGEN: assert property (hit_sys |=> regen_clock_source
        == $past(wr_data[BIT_REGEN_SRC]))
        else $error("clock source not taken from write");
    AST_MASTER: assert property (clock_master != regen_clock_source)
        else $error("clock master disagrees with clock source");
    AST_DACSRC: assert property (hit_sys |=> dac_source_select
        == $past(wr_data[BIT_DAC_SRC]))
        else $error("DAC source not taken from write");
    AST_FORMAT: assert property (hit_sys |=> serial_format
        == $past(wr_data[FMT_HI:FMT_LO]))
        else $error("serial format not taken from write");
    AST_SOUND: assert property (hit_snd |=> snd_reg == ($past(wr_data) & SOUND_MASK))
        else $error("sound register not updated");
    AST_SOFTMUTE: assert property (restore |=> soft_mute_enable)
        else $error("soft mute not default after restore");
    AST_HARDMUTE: assert property (lock_loss_mute && !pll_locked ##1 lock_loss_mute
        |-> hard_mute)
        else $error("no hard mute on lock loss");
    AST_PLLRST: assert property (hit_mux |=> pll_reset_hold
        == $past(wr_data[BIT_PLL_RESET]))
        else $error("PLL reset bit not taken from write");
    AST_VOLMUTE: assert property (hit_vol && wr_data[VOL_HI:0] == 6'h3F |=> volume_full_mute
        && volume_atten_db == VOL_MAX_ATTEN)
        else $error("top volume code does not mute");
    AST_STATUS: assert property (rd_load && rd_addr_reg == REG_LOCK |=>
        rd_shift_reg[15:0] == $past(lock_word))
        else $error("lock status readback wrong");
    AST_MASK: assert property ((mux_reg & ~MULTIPLEX_MASK) == 16'h0000
        && (sys_reg & ~SYSTEM_MASK) == 16'h0000)
        else $error("unassigned bits stored");
    AST_NO_EARLY: assert property (data_byte && state_reg == ST_DATA_HI |=>
        $stable(sys_reg) && $stable(mux_reg))
        else $error("register changed before second data byte");

endmodule : dcr_top
